// ---- core/dccu_pkg.sv ----
package dccu_pkg;

  // ---------------------------------------------------------------
  // register offsets of the unit pair (byte index on the link)
  // ---------------------------------------------------------------
  localparam logic [1:0][7:0] DCCU_CTRL_OFS = {8'h1D, 8'h17};
  localparam logic [1:0][7:0] DCCU_VLO_OFS = {8'h1B, 8'h15};
  localparam logic [1:0][7:0] DCCU_VHI_OFS = {8'h1C, 8'h16};
  localparam logic [1:0][7:0] DCCU_FLAG_OFS = {8'h0D, 8'h0C};
  localparam logic [1:0][2:0] DCCU_FLAG_POS = {3'h0, 3'h2};

  // ---------------------------------------------------------------
  // controller-side registers
  // ---------------------------------------------------------------
  localparam logic [7:0] DCCU_TMR_LO_OFS = 8'h0E;
  localparam logic [7:0] DCCU_TMR_HI_OFS = 8'h0F;
  localparam logic [7:0] DCCU_TMR_CTL_OFS = 8'h10;
  localparam logic [7:0] DCCU_PORT_DATA_OFS = 8'h07;
  localparam logic [7:0] DCCU_PORT_DIR_OFS = 8'h87;
  localparam int DCCU_TMR_ON_POS = 0;
  localparam int DCCU_ADC_EN_POS = 1;

  // ---------------------------------------------------------------
  // control field layout and reset values
  // ---------------------------------------------------------------
  localparam int DCCU_DUTY_LSB_POS = 4;
  localparam int DCCU_CTRL_W = 6;
  localparam logic [5:0] DCCU_CTRL_RST = 6'h00;
  localparam logic [1:0] DCCU_DIR_RST = 2'h3;
  localparam logic [3:0] DCCU_PRE4_LAST = 4'h3;
  localparam logic [3:0] DCCU_PRE16_LAST = 4'hF;

  // ---------------------------------------------------------------
  // mode select codes
  // ---------------------------------------------------------------
  localparam logic [3:0] DCCU_MODE_OFF = 4'h0;
  localparam logic [3:0] DCCU_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] DCCU_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] DCCU_MODE_CAP_4 = 4'h6;
  localparam logic [3:0] DCCU_MODE_CAP_16 = 4'h7;
  localparam logic [3:0] DCCU_MODE_CMP_SET = 4'h8;
  localparam logic [3:0] DCCU_MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] DCCU_MODE_CMP_SWI = 4'hA;
  localparam logic [3:0] DCCU_MODE_CMP_SPEC = 4'hB;
  localparam logic [1:0] DCCU_GRP_CAP = 2'h1;
  localparam logic [1:0] DCCU_GRP_CMP = 2'h2;
  localparam logic [1:0] DCCU_GRP_PWM = 2'h3;

  typedef struct packed {
    logic [7:0] valLo;
    logic [7:0] valHi;
    logic [5:0] ctrl;
    logic flag;
    logic outLat;
    logic drv;
    logic [3:0] pre;
    logic syn1;
    logic syn2;
    logic last;
    logic [9:0] duty;
  } dccu_unit_type;

endpackage

// ---- core/dccu_if.sv ----
`timescale 1ns/10ps
interface dccu_if;
  // register access from the controller
  logic reqStb;
  logic reqWe;
  logic [7:0] reqAddr;
  logic [7:0] reqData;
  logic rspAck;
  logic [7:0] rspData;
  // shared time base
  logic [15:0] timerCount;
  logic periodTick;
  logic specialClear;
  logic convStart;
  // unit pins
  logic [1:0] pinLevel;
  logic [1:0] unitDrive;
  logic [1:0] unitLevel;

  modport dev (
    input reqStb, reqWe, reqAddr, reqData, timerCount, periodTick,
    input pinLevel,
    output rspAck, rspData, specialClear, convStart, unitDrive,
    output unitLevel
  );
  modport ctl (
    output reqStb, reqWe, reqAddr, reqData, timerCount, periodTick,
    output pinLevel,
    input rspAck, rspData, specialClear, convStart, unitDrive,
    input unitLevel
  );
endinterface

// ---- core/dccu_unit_pair.sv ----
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
module dccu_unit_pair
  import dccu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to controller
  dccu_if.dev link,
  // user side
  output logic [1:0] unitFlag,
  output logic [1:0][9:0] pwmDuty
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    dccu_unit_type [1:0] u;
    logic ack;
    logic [7:0] rdata;
    logic special;
    logic adcGo;
  } dccu_dev_type;

  dccu_dev_type state_ff;
  dccu_dev_type nxt_state;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] mode;
    logic [3:0] newMode;
    logic rise;
    logic fall;
    logic capHit;
    logic match;
    logic [9:0] dutyNew;
    mode = 4'h0;
    newMode = 4'h0;
    rise = 1'b0;
    fall = 1'b0;
    capHit = 1'b0;
    match = 1'b0;
    dutyNew = 10'h000;
    nxt_state = state_ff;
    nxt_state.ack = 1'b0;
    nxt_state.rdata = 8'h00;
    nxt_state.special = 1'b0;
    nxt_state.adcGo = 1'b0;
    if (link.reqStb) begin
      nxt_state.ack = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      mode = state_ff.u[i].ctrl[3:0];
      // two stages before any edge logic sees the pin
      nxt_state.u[i].syn1 = link.pinLevel[i];
      nxt_state.u[i].syn2 = state_ff.u[i].syn1;
      nxt_state.u[i].last = state_ff.u[i].syn2;
      rise = state_ff.u[i].syn2 & ~state_ff.u[i].last;
      fall = ~state_ff.u[i].syn2 & state_ff.u[i].last;

      // software access first, so hardware events win over every write except a mode-off write
      if (link.reqStb) begin
        if (link.reqAddr == DCCU_CTRL_OFS[i]) begin
          nxt_state.rdata = {2'h0, state_ff.u[i].ctrl};
        end
        if (link.reqAddr == DCCU_VLO_OFS[i]) begin
          nxt_state.rdata = state_ff.u[i].valLo;
        end
        if (link.reqAddr == DCCU_VHI_OFS[i]) begin
          nxt_state.rdata = state_ff.u[i].valHi;
        end
        if (link.reqAddr == DCCU_FLAG_OFS[i]) begin
          nxt_state.rdata[DCCU_FLAG_POS[i]] = state_ff.u[i].flag;
        end
      end
      if (link.reqStb && link.reqWe) begin
        if (link.reqAddr == DCCU_CTRL_OFS[i]) begin
          nxt_state.u[i].ctrl = link.reqData[DCCU_CTRL_W-1:0];
          newMode = link.reqData[3:0];
          if (newMode == DCCU_MODE_OFF) begin
            nxt_state.u[i].outLat = 1'b0;
          end
        end
        if (link.reqAddr == DCCU_VLO_OFS[i]) begin
          nxt_state.u[i].valLo = link.reqData;
        end
        if (link.reqAddr == DCCU_VHI_OFS[i]) begin
          nxt_state.u[i].valHi = link.reqData;
        end
        if (link.reqAddr == DCCU_FLAG_OFS[i]) begin
          nxt_state.u[i].flag = link.reqData[DCCU_FLAG_POS[i]];
        end
      end

      // capture event selection
      capHit = 1'b0;
      case (mode)
        DCCU_MODE_CAP_FALL: begin
          capHit = fall;
        end
        DCCU_MODE_CAP_RISE: begin
          capHit = rise;
        end
        DCCU_MODE_CAP_4: begin
          // counter kept across prescale changes, may fire early
          if (rise) begin
            if (state_ff.u[i].pre[1:0] == DCCU_PRE4_LAST[1:0]) begin
              capHit = 1'b1;
              nxt_state.u[i].pre = 4'h0;
            end else begin
              nxt_state.u[i].pre = state_ff.u[i].pre + 4'h1;
            end
          end
        end
        DCCU_MODE_CAP_16: begin
          if (rise) begin
            capHit = state_ff.u[i].pre == DCCU_PRE16_LAST;
            nxt_state.u[i].pre = state_ff.u[i].pre + 4'h1;
          end
        end
        default: begin
          nxt_state.u[i].pre = 4'h0;
        end
      endcase
      if (capHit) begin
        // an unread value is simply replaced
        nxt_state.u[i].valLo = link.timerCount[7:0];
        nxt_state.u[i].valHi = link.timerCount[15:8];
        nxt_state.u[i].flag = 1'b1;
      end

      // compare against the shared timer every cycle
      match = (mode[3:2] == DCCU_GRP_CMP) &&
              ({state_ff.u[i].valHi, state_ff.u[i].valLo} ==
               link.timerCount);
      if (match) begin
        nxt_state.u[i].flag = 1'b1;
        case (mode)
          DCCU_MODE_CMP_SET: begin
            nxt_state.u[i].outLat = 1'b1;
          end
          DCCU_MODE_CMP_CLR: begin
            nxt_state.u[i].outLat = 1'b0;
          end
          DCCU_MODE_CMP_SWI: begin
            nxt_state.u[i].outLat = state_ff.u[i].outLat;
          end
          DCCU_MODE_CMP_SPEC: begin
            nxt_state.special = 1'b1;
            if (i == 1) begin
              nxt_state.adcGo = 1'b1;
            end
          end
          default: begin
            nxt_state.special = nxt_state.special;
          end
        endcase
      end

      // duty taken on the common period tick keeps edges aligned
      if (mode[3:2] == DCCU_GRP_PWM) begin
        dutyNew = {state_ff.u[i].valLo,
                   state_ff.u[i].ctrl[DCCU_DUTY_LSB_POS+:2]};
        if (link.periodTick) begin
          nxt_state.u[i].duty = dutyNew;
          nxt_state.u[i].outLat = dutyNew != 10'h000;
        end else if ({link.timerCount[7:0], 2'h0} >=
                     state_ff.u[i].duty) begin
          nxt_state.u[i].outLat = 1'b0;
        end
      end

      // new mode decides, so a clear beats a match in the same cycle
      newMode = nxt_state.u[i].ctrl[3:0];
      if (newMode == DCCU_MODE_OFF) begin
        nxt_state.u[i].outLat = 1'b0;
        nxt_state.u[i].pre = 4'h0;
        nxt_state.u[i].duty = 10'h000;
      end
      nxt_state.u[i].drv = (newMode == DCCU_MODE_CMP_SET) ||
                           (newMode == DCCU_MODE_CMP_CLR) ||
                           (newMode[3:2] == DCCU_GRP_PWM);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.rspAck = state_ff.ack;
  assign link.rspData = state_ff.rdata;
  assign link.specialClear = state_ff.special;
  assign link.convStart = state_ff.adcGo;

  for (genvar g = 0; g < 2; g++) begin : g_out
    assign link.unitDrive[g] = state_ff.u[g].drv;
    assign link.unitLevel[g] = state_ff.u[g].outLat;
    assign unitFlag[g] = state_ff.u[g].flag;
    assign pwmDuty[g] = state_ff.u[g].duty;
  end

endmodule

// ---- core/dccu_ctl.sv ----
`timescale 1ns/10ps
module dccu_ctl
  import dccu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to the unit pair
  dccu_if.ctl link,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic [1:0] pinIn,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe_n,
  output logic adcStart
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] timer;
    logic [1:0] tctl;
    logic [1:0] dir;
    logic [1:0] portLat;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] level;
    logic [1:0] pOut;
    logic [1:0] pOe;
    logic busy;
    logic rStb;
    logic rWe;
    logic [7:0] rAddr;
    logic [7:0] rData;
    logic ack;
    logic [7:0] dat;
    logic tick;
    logic adc;
  } dccu_ctl_type;

  dccu_ctl_type state_ff;
  dccu_ctl_type nxt_state;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] idx;
    logic take;
    logic wr;
    logic [1:0] drive;
    idx = wb_adr_i[9:2];
    take = wb_cyc_i & wb_stb_i & ~state_ff.ack & ~state_ff.busy;
    wr = take & wb_we_i & wb_sel_i[0];
    drive = 2'h0;
    nxt_state = state_ff;
    nxt_state.ack = 1'b0;
    nxt_state.rStb = 1'b0;
    if (take) begin
      case (idx)
        DCCU_TMR_LO_OFS: begin
          nxt_state.ack = 1'b1;
          nxt_state.dat = state_ff.timer[7:0];
        end
        DCCU_TMR_HI_OFS: begin
          nxt_state.ack = 1'b1;
          nxt_state.dat = state_ff.timer[15:8];
        end
        DCCU_TMR_CTL_OFS: begin
          nxt_state.ack = 1'b1;
          nxt_state.dat = {6'h00, state_ff.tctl};
          if (wr) nxt_state.tctl = wb_dat_i[1:0];
        end
        DCCU_PORT_DATA_OFS: begin
          nxt_state.ack = 1'b1;
          nxt_state.dat = {6'h00, state_ff.portLat};
          if (wr) nxt_state.portLat = wb_dat_i[1:0];
        end
        DCCU_PORT_DIR_OFS: begin
          nxt_state.ack = 1'b1;
          nxt_state.dat = {6'h00, state_ff.dir};
          if (wr) nxt_state.dir = wb_dat_i[1:0];
        end
        default: begin
          // unit registers are forwarded; mode changes are software's
          nxt_state.busy = 1'b1;
          nxt_state.rStb = 1'b1;
          nxt_state.rWe = wb_we_i & wb_sel_i[0];
          nxt_state.rAddr = idx;
          nxt_state.rData = wb_dat_i[7:0];
        end
      endcase
    end
    if (state_ff.busy && link.rspAck) begin
      nxt_state.busy = 1'b0;
      nxt_state.ack = 1'b1;
      nxt_state.dat = link.rspData;
    end

    // synchronous time base only, never a free-running async count
    if (link.specialClear) begin
      nxt_state.timer = 16'h0000;
    end else if (wr && idx == DCCU_TMR_LO_OFS) begin
      nxt_state.timer[7:0] = wb_dat_i[7:0];
    end else if (wr && idx == DCCU_TMR_HI_OFS) begin
      nxt_state.timer[15:8] = wb_dat_i[7:0];
    end else if (state_ff.tctl[DCCU_TMR_ON_POS]) begin
      nxt_state.timer = state_ff.timer + 16'h0001;
    end
    nxt_state.tick = state_ff.tctl[DCCU_TMR_ON_POS] &
                     (state_ff.timer[7:0] == 8'hFF);
    nxt_state.adc = link.convStart & state_ff.tctl[DCCU_ADC_EN_POS];

    // pins: unit latch overrides port latch while the unit drives
    nxt_state.s1 = pinIn;
    nxt_state.s2 = state_ff.s1;
    for (int i = 0; i < 2; i++) begin
      drive[i] = link.unitDrive[i] ? link.unitLevel[i] :
                 state_ff.portLat[i];
    end
    nxt_state.pOut = drive;
    nxt_state.pOe = state_ff.dir;
    nxt_state.level = (state_ff.dir & state_ff.s2) |
                      (~state_ff.dir & state_ff.pOut);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.dir <= DCCU_DIR_RST;
      state_ff.pOe <= DCCU_DIR_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.reqStb = state_ff.rStb;
  assign link.reqWe = state_ff.rWe;
  assign link.reqAddr = state_ff.rAddr;
  assign link.reqData = state_ff.rData;
  assign link.timerCount = state_ff.timer;
  assign link.periodTick = state_ff.tick;
  assign link.pinLevel = state_ff.level;
  assign wb_dat_o = {24'h000000, state_ff.dat};
  assign wb_ack_o = state_ff.ack;
  assign pinOut = state_ff.pOut;
  assign pinOe_n = state_ff.pOe;
  assign adcStart = state_ff.adc;

endmodule

// ---- verification/dccu_checker.sv ----
`timescale 1ns/10ps
module dccu_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link between the two ends
  input wire logic reqStb,
  input wire logic reqWe,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqData,
  input wire logic rspAck,
  input wire logic [7:0] rspData,
  input wire logic [15:0] timerCount,
  input wire logic specialClear,
  input wire logic convStart,
  input wire logic [1:0] unitDrive,
  input wire logic [1:0] unitLevel
);
  // ---------------------------------------
  // link and unit properties
  // ---------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  link_answer_a: assert property (
    reqStb |=> rspAck ##1 !rspAck)
    else $error("link request not answered in one cycle");
  ack_cause_a: assert property (
    rspAck |-> $past(reqStb))
    else $error("link answer without request");
  unmapped_zero_a: assert property (
    rspAck && !($past(reqAddr) inside {8'h15, 8'h16, 8'h17, 8'h1B,
    8'h1C, 8'h1D, 8'h0C, 8'h0D}) |-> rspData == 8'h00)
    else $error("unmapped index read not zero");
  ctrl_top_zero_a: assert property (
    rspAck && $past(reqAddr) inside {8'h17, 8'h1D} |-> rspData[7:6] == 2'h0)
    else $error("control upper bits not zero");
  clear_one_low_a: assert property (
    reqStb && reqWe && reqAddr == 8'h17 && reqData[3:0] == 4'h0
    |=> !unitLevel[0] && !unitDrive[0])
    else $error("unit one latch not low after clear");
  clear_two_low_a: assert property (
    reqStb && reqWe && reqAddr == 8'h1D && reqData[3:0] == 4'h0
    |=> !unitLevel[1] && !unitDrive[1])
    else $error("unit two latch not low after clear");
  drive_cmp_a: assert property (
    reqStb && reqWe && reqAddr == 8'h17 && reqData[3:1] == 3'h4
    |-> ##[1:2] unitDrive[0])
    else $error("compare output mode does not own pin");
  conv_with_clear_a: assert property (
    convStart |-> specialClear)
    else $error("conversion start without special event");
  timer_clear_a: assert property (
    specialClear |=> timerCount == 16'h0000)
    else $error("special event did not clear timer");
endmodule

// ---- verification/test_dual_capture_compare_unit.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  samplesChecked++; \
  if ((got) !== (exp)) begin \
    failCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module test_dual_capture_compare_unit;
  import dccu_pkg::*;
  // ---------------------------------------
  // signals and instances
  // ---------------------------------------
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [9:0] adr = 10'h000;
  logic [31:0] datI = 32'h0;
  logic [31:0] datO;
  logic ack;
  logic adcStart;
  logic [1:0] pinOut;
  logic [1:0] pinOe_n;
  logic [1:0] extDrv = 2'h0;
  logic [1:0] unitFlag;
  logic [1:0][9:0] pwmDuty;
  logic [7:0] rdq;
  int failCount = 0;
  int samplesChecked = 0;
  // pin level: our driver when enabled, else the outside world
  wire [1:0] pinIn = (~pinOe_n & pinOut) | (pinOe_n & extDrv);

  always #20 clk = ~clk;

  dccu_if dccu_if_inst ();
  dccu_unit_pair dccu_unit_pair_inst (.clk(clk), .rst(rst),
    .link(dccu_if_inst.dev), .unitFlag(unitFlag), .pwmDuty(pwmDuty));
  dccu_ctl dccu_ctl_inst (.clk(clk), .rst(rst), .link(dccu_if_inst.ctl),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(datI), .wb_sel_i(4'hF), .wb_dat_o(datO), .wb_ack_o(ack),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .adcStart(adcStart));
  dccu_checker dccu_checker_inst (.clk(clk), .rst(rst),
    .reqStb(dccu_if_inst.reqStb), .reqWe(dccu_if_inst.reqWe),
    .reqAddr(dccu_if_inst.reqAddr), .reqData(dccu_if_inst.reqData),
    .rspAck(dccu_if_inst.rspAck), .rspData(dccu_if_inst.rspData),
    .timerCount(dccu_if_inst.timerCount),
    .specialClear(dccu_if_inst.specialClear),
    .convStart(dccu_if_inst.convStart),
    .unitDrive(dccu_if_inst.unitDrive), .unitLevel(dccu_if_inst.unitLevel));

  // ---------------------------------------
  // bus and pin tasks
  // ---------------------------------------
  // entered at an edge; registered outputs read there are pre-edge values
  task automatic wb(input logic [7:0] idx, input logic wr,
                    input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= wr;
    adr <= {idx, 2'h0};
    datI <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (ack !== 1'h1) failCount++;
    rdq = datO[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(idx, 1'h1, d);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] e);
    wb(idx, 1'h0, 8'h00);
    `CHK(rdq, e)
  endtask

  // 8 cycles cover the 3 controller and 3 unit stages, with margin
  task automatic pin(input logic v);
    extDrv[0] <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic capN(input logic [7:0] mode, input int n);
    wr(8'h17, 8'h00);
    wr(8'h17, mode);
    wr(8'h0C, 8'h00);
    wr(8'h0E, 8'h00);
    repeat (n - 1) begin
      pin(1'h1);
      pin(1'h0);
    end
    rdChk(8'h0C, 8'h00);
    wr(8'h0E, mode);
    pin(1'h1);
    pin(1'h0);
    rdChk(8'h15, mode);
  endtask

  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  task automatic tReset();
    rdChk(8'h17, 8'h00);
    rdChk(8'h1D, 8'h00);
    rdChk(8'h0C, 8'h00);
    rdChk(8'h30, 8'h00);
    `CHK(pinOe_n, 2'h3)
    $display("reset test done");
  endtask

  task automatic tBytes();
    logic [7:0] ix [4];
    ix = '{8'h15, 8'h16, 8'h1B, 8'h1C};
    foreach (ix[i]) wr(ix[i], 8'hA5 ^ ix[i]);
    foreach (ix[i]) rdChk(ix[i], 8'hA5 ^ ix[i]);
    $display("value byte test done");
  endtask

  task automatic tCapture();
    wr(8'h0E, 8'h78);
    wr(8'h0F, 8'h56);
    wr(8'h17, 8'h05);
    wr(8'h0C, 8'h00);
    pin(1'h1);
    rdChk(8'h15, 8'h78);
    rdChk(8'h16, 8'h56);
    `CHK(unitFlag[0], 1'h1)
    wr(8'h0F, 8'h9A);
    pin(1'h0);
    rdChk(8'h16, 8'h56);
    pin(1'h1);
    rdChk(8'h16, 8'h9A);
    rdChk(8'h0C, 8'h04);
    wr(8'h17, 8'h00);
    wr(8'h17, 8'h04);
    wr(8'h0E, 8'h11);
    pin(1'h0);
    rdChk(8'h15, 8'h11);
    capN(8'h06, 4);
    capN(8'h07, 16);
    wr(8'h07, 8'h00);
    wr(8'h87, 8'h02);
    wr(8'h17, 8'h00);
    wr(8'h17, 8'h05);
    wr(8'h0E, 8'h33);
    wr(8'h07, 8'h01);
    repeat (8) @(posedge clk);
    rdChk(8'h15, 8'h33);
    $display("capture test done");
  endtask

  task automatic tCompare();
    wr(8'h17, 8'h00);
    wr(8'h87, 8'h00);
    wr(8'h0E, 8'h00);
    wr(8'h0F, 8'h00);
    wr(8'h15, 8'h10);
    wr(8'h16, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h17, 8'h08);
    rdChk(8'h0C, 8'h00);
    `CHK(pinOut[0], 1'h0)
    wr(8'h0E, 8'h10);
    // pin follows the unit latch one cycle after the link shows it
    repeat (2) @(posedge clk);
    `CHK(pinOut[0], 1'h1)
    rdChk(8'h0C, 8'h04);
    wr(8'h17, 8'h09);
    repeat (2) @(posedge clk);
    `CHK(pinOut[0], 1'h0)
    wr(8'h17, 8'h08);
    wr(8'h17, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(dccu_if_inst.unitLevel[0], 1'h0)
    // port latch still holds 1 and owns the pin again
    `CHK(pinOut[0], 1'h1)
    wr(8'h0C, 8'h00);
    wr(8'h17, 8'h0A);
    repeat (2) @(posedge clk);
    `CHK(pinOut[0], 1'h1)
    `CHK(dccu_if_inst.unitLevel[0], 1'h0)
    rdChk(8'h0C, 8'h04);
    $display("compare test done");
  endtask

  task automatic tSpecial();
    int n;
    n = 0;
    wr(8'h1B, 8'h40);
    wr(8'h1C, 8'h00);
    wr(8'h1D, 8'h0B);
    wr(8'h0D, 8'h00);
    wr(8'h0E, 8'h00);
    wr(8'h10, 8'h03);
    while (adcStart !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    `CHK(adcStart, 1'h1)
    wr(8'h0C, 8'h00);
    repeat (300) @(posedge clk);
    rdChk(8'h0F, 8'h00);
    rdChk(8'h0D, 8'h01);
    rdChk(8'h0C, 8'h04);
    wr(8'h10, 8'h00);
    $display("special event test done");
  endtask

  task automatic tPwm();
    logic [1:0] p;
    wr(8'h17, 8'h00);
    wr(8'h1D, 8'h00);
    wr(8'h15, 8'h40);
    wr(8'h1B, 8'h80);
    wr(8'h17, 8'h1C);
    wr(8'h1D, 8'h0C);
    wr(8'h0E, 8'h00);
    wr(8'h10, 8'h01);
    repeat (300) @(posedge clk);
    `CHK(pwmDuty[0], 10'h101)
    `CHK(pwmDuty[1], 10'h200)
    p = pinOut;
    // differing duties, so only the rising edges must coincide
    repeat (600) begin
      @(posedge clk);
      if (pinOut[0] && !p[0]) `CHK(!p[1] && pinOut[1], 1'h1)
      p = pinOut;
    end
    wr(8'h17, 8'h00);
    `CHK(pwmDuty[0], 10'h000)
    $display("pwm test done");
  endtask

  task automatic endSim();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    failCount++;
    endSim();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    tReset();
    tBytes();
    tCapture();
    tCompare();
    tSpecial();
    tPwm();
    endSim();
  end
endmodule
